// File: scifc_bridge.sv
// Indirect switch register access bridge with per-port flow control enables
`include "scifc_map.svh"
module scifc_bridge (
    input  wire logic        clk_i,          // System clock, 100 MHz
    input  wire logic        reset_i,        // Synchronous reset, active high
    input  wire logic [11:0] host_addr_i,    // Host register byte address
    input  wire logic        host_wr_i,      // Host write strobe
    input  wire logic        host_rd_i,      // Host read strobe
    input  wire logic [31:0] host_wdata_i,   // Host write data
    output logic      [31:0] host_rdata_o,   // Host read data, one cycle later
    output logic             fab_req_o,      // Internal access request
    output logic             fab_rd_o,       // Internal access is a read
    output logic      [15:0] fab_index_o,    // Internal register index
    output logic      [3:0]  fab_lanes_o,    // Internal byte lane selects
    output logic      [31:0] fab_wdata_o,    // Internal write data
    input  wire logic        fab_ack_i,      // Internal access done
    input  wire logic [31:0] fab_rdata_i,    // Internal read data
    input  wire logic [2:0]  full_dup_i,     // Port full duplex
    input  wire logic [2:0]  an_en_i,        // Port auto-negotiation enabled
    input  wire logic [2:0]  an_done_i,      // Port negotiation complete
    input  wire logic [2:0]  lp_able_i,      // Port partner can negotiate
    input  wire logic [2:0]  adv_pause_i,    // Port local pause advertisement
    input  wire logic [2:0]  adv_asym_i,     // Port local asymmetric advertisement
    input  wire logic [2:0]  lp_pause_i,     // Port partner pause ability
    input  wire logic [2:0]  lp_asym_i,      // Port partner asymmetric ability
    output logic      [2:0]  tx_fc_en_o,     // Port transmit flow control enable
    output logic      [2:0]  rx_fc_en_o      // Port receive flow control enable
);
    // ======================================================================
    // State
    scifc_pkg::scifc_state_type state, next_state;
    logic [31:0] data, next_data;
    logic        pending, next_pending;
    logic        rd_flag, next_rd_flag;
    logic        step_up, next_step_up;
    logic        step_down, next_step_down;
    logic [3:0]  lanes, next_lanes;
    logic [15:0] index, next_index;
    logic [3:0]  fc_ovr [3];
    logic [3:0]  next_fc_ovr [3];
    logic [31:0] next_rdata;
    logic [2:0]  next_tx_fc, next_rx_fc;
    logic [15:0] stepped_index;

    // ======================================================================
    // Address decode
    logic hit_data, hit_cmd, hit_stat, hit_win;
    logic [2:0] hit_fc;
    logic [31:0] cmd_view;

    always_comb begin
        hit_data = 1'b0;
        hit_cmd  = 1'b0;
        hit_stat = 1'b0;
        hit_win  = 1'b0;
        hit_fc   = 3'h0;
        if (host_addr_i[11:8] == `SCIFC_WIN_SEL) begin
            hit_win = 1'b1;
        end else if (host_addr_i == `SCIFC_OFS_DATA) begin
            hit_data = 1'b1;
        end else if (host_addr_i == `SCIFC_OFS_CMD) begin
            hit_cmd = 1'b1;
        end else if (host_addr_i == `SCIFC_OFS_FC_PORT0) begin
            hit_fc[0] = 1'b1;
        end else if (host_addr_i == `SCIFC_OFS_FC_PORT1) begin
            hit_fc[1] = 1'b1;
        end else if (host_addr_i == `SCIFC_OFS_FC_PORT2) begin
            hit_fc[2] = 1'b1;
        end else if (host_addr_i == `SCIFC_OFS_FC_STAT) begin
            hit_stat = 1'b1;
        end
    end

    always_comb begin
        cmd_view = 32'h0000_0000;
        cmd_view[`SCIFC_CMD_PEND] = pending;
        cmd_view[`SCIFC_CMD_RD]   = rd_flag;
        cmd_view[`SCIFC_CMD_UP]   = step_up;
        cmd_view[`SCIFC_CMD_DOWN] = step_down;
        cmd_view[`SCIFC_CMD_LANE_HI:`SCIFC_CMD_LANE_LO] = lanes;
        cmd_view[`SCIFC_CMD_IDX_HI:`SCIFC_CMD_IDX_LO]   = index;
    end

    // ======================================================================
    // Access sequencing
    logic ack_now, step_read, data_start;
    assign ack_now    = (state == scifc_pkg::SCIFC_WAIT) && fab_ack_i;
    // A data read in stepping read mode launches the next read
    assign step_read  = host_rd_i && hit_data && !pending && rd_flag && (step_up || step_down);
    assign data_start = host_wr_i && hit_data && !pending && !rd_flag && (step_up || step_down);

    scifc_index_step u_step (
        .index_i (index),
        .up_i    (step_up),
        .down_i  (step_down),
        .index_o (stepped_index)
    );

    always_comb begin
        next_state     = state;
        next_data      = data;
        next_pending   = pending;
        next_rd_flag   = rd_flag;
        next_step_up   = step_up;
        next_step_down = step_down;
        next_lanes     = lanes;
        next_index     = index;
        case (state)
            scifc_pkg::SCIFC_IDLE: begin
                // Starts while pending are dropped; the host must wait
                if (host_wr_i && !pending) begin
                    if (hit_win) begin
                        next_data    = host_wdata_i;
                        next_index   = {`SCIFC_WIN_PAD, host_addr_i[7:2]};
                        next_lanes   = `SCIFC_LANES_ALL;
                        next_rd_flag = 1'b0;
                        next_pending = 1'b1;
                    end else if (hit_data) begin
                        next_data    = host_wdata_i;
                        next_pending = data_start;
                    end else if (hit_cmd) begin
                        next_pending   = host_wdata_i[`SCIFC_CMD_PEND];
                        next_rd_flag   = host_wdata_i[`SCIFC_CMD_RD];
                        next_step_up   = host_wdata_i[`SCIFC_CMD_UP];
                        next_step_down = host_wdata_i[`SCIFC_CMD_DOWN];
                        next_lanes = host_wdata_i[`SCIFC_CMD_LANE_HI:`SCIFC_CMD_LANE_LO];
                        next_index = host_wdata_i[`SCIFC_CMD_IDX_HI:`SCIFC_CMD_IDX_LO];
                    end
                end else if (step_read) begin
                    next_index   = stepped_index;
                    next_pending = 1'b1;
                end
                if (next_pending) begin
                    next_state = scifc_pkg::SCIFC_WAIT;
                end
            end
            scifc_pkg::SCIFC_WAIT: begin
                if (fab_ack_i) begin
                    if (rd_flag) begin
                        next_data = fab_rdata_i;
                    end else begin
                        next_index = stepped_index;
                    end
                    next_pending = 1'b0;
                    next_state   = scifc_pkg::SCIFC_IDLE;
                end
            end
            default: begin
                next_state   = scifc_pkg::SCIFC_IDLE;
                next_pending = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state     <= scifc_pkg::SCIFC_IDLE;
            data      <= `SCIFC_DATA_RESET;
            pending   <= 1'b0;
            rd_flag   <= 1'b0;
            step_up   <= 1'b0;
            step_down <= 1'b0;
            lanes     <= 4'h0;
            index     <= `SCIFC_IDX_RESET;
        end else begin
            state     <= next_state;
            data      <= next_data;
            pending   <= next_pending;
            rd_flag   <= next_rd_flag;
            step_up   <= next_step_up;
            step_down <= next_step_down;
            lanes     <= next_lanes;
            index     <= next_index;
        end
    end

    // Request is held for the whole internal cycle
    assign fab_req_o   = (state == scifc_pkg::SCIFC_WAIT);
    assign fab_rd_o    = rd_flag;
    assign fab_index_o = index;
    assign fab_lanes_o = lanes;
    assign fab_wdata_o = data;

    // ======================================================================
    // Flow control: override registers and per-port resolution
    logic [2:0] tx_fc, rx_fc;

    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_port
            scifc_flow_ctl u_fc (
                .override_i (fc_ovr[p]),
                .full_i     (full_dup_i[p]),
                .an_en_i    (an_en_i[p]),
                .an_done_i  (an_done_i[p]),
                .lp_able_i  (lp_able_i[p]),
                .pause_i    (adv_pause_i[p]),
                .asym_i     (adv_asym_i[p]),
                .lp_pause_i (lp_pause_i[p]),
                .lp_asym_i  (lp_asym_i[p]),
                .tx_en_o    (tx_fc[p]),
                .rx_en_o    (rx_fc[p])
            );
        end
    endgenerate

    // Override bits feed only the enables; advertisement inputs are never written
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_fc_ovr[i] = fc_ovr[i];
            if (host_wr_i && hit_fc[i]) begin
                next_fc_ovr[i] = host_wdata_i[3:0];
            end
        end
        next_tx_fc = tx_fc;
        next_rx_fc = rx_fc;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 3; i++) begin
                fc_ovr[i] <= `SCIFC_FC_RESET;
            end
            tx_fc_en_o <= 3'h0;
            rx_fc_en_o <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                fc_ovr[i] <= next_fc_ovr[i];
            end
            tx_fc_en_o <= next_tx_fc;
            rx_fc_en_o <= next_rx_fc;
        end
    end

    // ======================================================================
    // Read data path; unmapped addresses and the window read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (host_rd_i) begin
            if (hit_data) begin
                next_rdata = data;
            end else if (hit_cmd) begin
                next_rdata = cmd_view;
            end else if (hit_fc[0]) begin
                next_rdata = {28'h000_0000, fc_ovr[0]};
            end else if (hit_fc[1]) begin
                next_rdata = {28'h000_0000, fc_ovr[1]};
            end else if (hit_fc[2]) begin
                next_rdata = {28'h000_0000, fc_ovr[2]};
            end else if (hit_stat) begin
                next_rdata = {23'h00_0000, pending, 1'b0, rx_fc_en_o, 1'b0, tx_fc_en_o};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            host_rdata_o <= 32'h0000_0000;
        end else begin
            host_rdata_o <= next_rdata;
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_pending_hold: assert property (fab_req_o |-> pending)
        else $error("pending low during internal cycle");
    a_pending_clear: assert property (ack_now |=> !pending && !fab_req_o)
        else $error("pending not cleared after completion");
    a_write_step: assert property (ack_now && !rd_flag && step_up && !step_down
        |=> index == 16'($past(index) + 16'h0001))
        else $error("index not stepped after stepping write");
    a_window_load: assert property (host_wr_i && hit_win && !pending
        |=> pending && lanes == 4'hF && !rd_flag && fab_req_o)
        else $error("window write did not start write");
    a_read_data: assert property (ack_now && rd_flag
        |=> data == $past(fab_rdata_i) && !pending)
        else $error("read data not captured");
    a_read_step: assert property (step_read && step_up
        |=> pending && index == 16'($past(index) + 16'h0001))
        else $error("stepping read did not restart");
    a_half_jam: assert property (!an_en_i[1] && !full_dup_i[1]
        |=> tx_fc_en_o[1] == $past(fc_ovr[1][2]) && !rx_fc_en_o[1])
        else $error("half duplex tx enable not jam bit");
    a_an_wait: assert property (an_en_i[1] && !fc_ovr[1][3] && !an_done_i[1]
        |=> !tx_fc_en_o[1] && !rx_fc_en_o[1])
        else $error("enables set while negotiation pending");
    a_forced_full: assert property (fc_ovr[2][3] && full_dup_i[2]
        |=> tx_fc_en_o[2] == $past(fc_ovr[2][1]) && rx_fc_en_o[2] == $past(fc_ovr[2][0]))
        else $error("forced pause bits not followed");
    // Fields other than the index, data and pending flag only change in idle, so they must hold
    a_busy_ignore: assert property (pending && host_wr_i && (hit_cmd || hit_data || hit_win)
        |=> $stable(lanes) && $stable(rd_flag) && $stable(step_up) && $stable(step_down))
        else $error("access taken while pending");

    c_single_write: cover property (host_wr_i && hit_cmd && !pending ##1 fab_req_o && !fab_rd_o
        ##[1:20] ack_now);
    c_single_read: cover property (fab_req_o && fab_rd_o ##0 fab_ack_i);
    c_window_write: cover property (host_wr_i && hit_win && !pending ##[1:20] ack_now);
    c_step_read: cover property (step_read ##[1:20] ack_now);
endmodule

// File: scifc_fabric_model.sv
// Behavioural model of the switch register space behind the bridge
module scifc_fabric_model (
    input  wire logic        clk_i,    // System clock
    input  wire logic        reset_i,  // Synchronous reset, active high
    input  wire logic        req_i,    // Access request
    input  wire logic        rd_i,     // Access is a read
    input  wire logic [15:0] index_i,  // Register index
    input  wire logic [3:0]  lanes_i,  // Byte lane selects
    input  wire logic [31:0] wdata_i,  // Write data
    input  wire logic [3:0]  delay_i,  // Wait cycles before acknowledge
    output logic             ack_o,    // One-cycle access done
    output logic      [31:0] rdata_o   // Read data, valid with ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255];
    logic [3:0]  cnt;
    // ==========================================================================
    // Read data toggles outside the answer cycle, so a late sample never matches
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_o <= 1'b0;
            cnt <= 4'h0;
            rdata_o <= 32'h0000_0000;
            for (int i = 0; i < 256; i++) begin
                mem[i] <= 32'h0000_0000;
            end
        end else if (ack_o) begin
            ack_o <= 1'b0;
            cnt <= 4'h0;
            rdata_o <= ~rdata_o;
            for (int b = 0; b < 4; b++) begin
                if (req_i && !rd_i && lanes_i[b]) begin
                    mem[index_i[7:0]][8*b +: 8] <= wdata_i[8*b +: 8];
                end
            end
        end else if (req_i && cnt >= delay_i) begin
            ack_o <= 1'b1;
            rdata_o <= mem[index_i[7:0]];
        end else begin
            cnt <= req_i ? cnt + 4'h1 : 4'h0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule

// File: scifc_flow_ctl.sv
// Per-port transmit/receive flow control enable resolution
`include "scifc_map.svh"
module scifc_flow_ctl (
    input  wire logic [3:0] override_i,   // Port flow override register
    input  wire logic       full_i,       // Port runs full duplex
    input  wire logic       an_en_i,      // Auto-negotiation enabled
    input  wire logic       an_done_i,    // Auto-negotiation complete
    input  wire logic       lp_able_i,    // Partner can negotiate
    input  wire logic       pause_i,      // Local pause advertised
    input  wire logic       asym_i,       // Local asymmetric pause advertised
    input  wire logic       lp_pause_i,   // Partner pause ability
    input  wire logic       lp_asym_i,    // Partner asymmetric pause ability
    output logic            tx_en_o,      // Transmit flow control enable
    output logic            rx_en_o       // Receive flow control enable
);
    logic jam;
    assign jam = override_i[`SCIFC_FC_JAM];

    always_comb begin
        if (!an_en_i || override_i[`SCIFC_FC_OVR]) begin
            if (!full_i) begin
                tx_en_o = jam;
                rx_en_o = 1'b0;
            end else begin
                tx_en_o = override_i[`SCIFC_FC_TX];
                rx_en_o = override_i[`SCIFC_FC_RX];
            end
        end else if (!an_done_i) begin
            tx_en_o = 1'b0;
            rx_en_o = 1'b0;
        end else if (!lp_able_i || !full_i) begin
            // Parallel detect forces half duplex when the partner cannot negotiate
            tx_en_o = jam;
            rx_en_o = 1'b0;
        end else begin
            tx_en_o = (pause_i & lp_pause_i) | (!pause_i & asym_i & lp_pause_i & lp_asym_i);
            rx_en_o = (pause_i & lp_pause_i) | (pause_i & asym_i & !lp_pause_i & lp_asym_i);
        end
    end
endmodule

// File: scifc_index_step.sv
// Target index stepping: up, down or hold
`include "scifc_map.svh"
module scifc_index_step (
    input  wire logic [15:0] index_i,  // Current target index
    input  wire logic        up_i,     // Step up
    input  wire logic        down_i,   // Step down
    output logic      [15:0] index_o   // Stepped index
);
    always_comb begin
        if (up_i) begin
            index_o = 16'(index_i + `SCIFC_IDX_ONE);
        end else if (down_i) begin
            index_o = 16'(index_i - `SCIFC_IDX_ONE);
        end else begin
            index_o = index_i;
        end
    end
endmodule

// File: scifc_map.svh
// Register offsets, field positions and reset values of the indirect access bridge
`ifndef SCIFC_MAP_SVH
`define SCIFC_MAP_SVH

// ==========================================================================
// Register byte offsets
`define SCIFC_OFS_DATA      12'h000
`define SCIFC_OFS_CMD       12'h004
`define SCIFC_OFS_FC_PORT0  12'h008
`define SCIFC_OFS_FC_PORT1  12'h00C
`define SCIFC_OFS_FC_PORT2  12'h010
`define SCIFC_OFS_FC_STAT   12'h014
// Direct window occupies 0x200..0x2FC, 64 words
`define SCIFC_WIN_SEL       4'h2
`define SCIFC_WIN_PAD       10'h000

// ==========================================================================
// Command register fields
`define SCIFC_CMD_PEND      31
`define SCIFC_CMD_RD        30
`define SCIFC_CMD_UP        29
`define SCIFC_CMD_DOWN      28
`define SCIFC_CMD_LANE_HI   19
`define SCIFC_CMD_LANE_LO   16
`define SCIFC_CMD_IDX_HI    15
`define SCIFC_CMD_IDX_LO    0
`define SCIFC_LANES_ALL     4'hF

// ==========================================================================
// Flow override register fields
`define SCIFC_FC_RX         0
`define SCIFC_FC_TX         1
`define SCIFC_FC_JAM        2
`define SCIFC_FC_OVR        3
`define SCIFC_FC_RESET      4'h0

// ==========================================================================
// Reset values and index step
`define SCIFC_DATA_RESET    32'h0000_0000
`define SCIFC_IDX_RESET     16'h0000
`define SCIFC_IDX_ONE       16'h0001

`endif

// File: scifc_pkg.sv
// Types shared by the indirect access bridge
package scifc_pkg;
    typedef enum logic [1:0] {
        SCIFC_IDLE = 2'b01,
        SCIFC_WAIT = 2'b10
    } scifc_state_type;
endpackage

// File: scifc_tb.sv
// Self-checking bench of the indirect access bridge and flow control enables
`include "scifc_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        reset_i;
    logic [11:0] host_addr_i;
    logic        host_wr_i;
    logic        host_rd_i;
    logic [31:0] host_wdata_i;
    logic [31:0] host_rdata_o;
    logic        fab_req_o;
    logic        fab_rd_o;
    logic [15:0] fab_index_o;
    logic [3:0]  fab_lanes_o;
    logic [31:0] fab_wdata_o;
    logic        fab_ack_i;
    logic [31:0] fab_rdata_i;
    logic [2:0]  full_dup_i, an_en_i, an_done_i, lp_able_i;
    logic [2:0]  adv_pause_i, adv_asym_i, lp_pause_i, lp_asym_i;
    logic [2:0]  tx_fc_en_o, rx_fc_en_o;
    logic [3:0]  delay;
    logic [31:0] v;
    int          n_errors = 0;
    int          comparisons = 0;
    logic [11:0] fc_ofs [3] = '{`SCIFC_OFS_FC_PORT0, `SCIFC_OFS_FC_PORT1, `SCIFC_OFS_FC_PORT2};
    // Row: override reg, {full,an_en,an_done,lp_able}, {pause,asym,lp_pause,lp_asym}, {tx,rx}
    logic [15:0] rows [16] = '{16'hC7F2, 16'h4002, 16'hAFF2, 16'h1801, 16'h7DF0, 16'h4EF2,
                               16'h47F2, 16'h07F0, 16'h3F30, 16'h3F40, 16'h3F60, 16'h3F72,
                               16'h3F90, 16'h3FA3, 16'h3FC0, 16'h3FD1};
    scifc_bridge dut (.clk_i(clk_i), .reset_i(reset_i), .host_addr_i(host_addr_i),
        .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i),
        .host_rdata_o(host_rdata_o), .fab_req_o(fab_req_o), .fab_rd_o(fab_rd_o),
        .fab_index_o(fab_index_o), .fab_lanes_o(fab_lanes_o), .fab_wdata_o(fab_wdata_o),
        .fab_ack_i(fab_ack_i), .fab_rdata_i(fab_rdata_i), .full_dup_i(full_dup_i),
        .an_en_i(an_en_i), .an_done_i(an_done_i), .lp_able_i(lp_able_i),
        .adv_pause_i(adv_pause_i), .adv_asym_i(adv_asym_i), .lp_pause_i(lp_pause_i),
        .lp_asym_i(lp_asym_i), .tx_fc_en_o(tx_fc_en_o), .rx_fc_en_o(rx_fc_en_o));
    scifc_fabric_model fab (.clk_i(clk_i), .reset_i(reset_i), .req_i(fab_req_o),
        .rd_i(fab_rd_o), .index_i(fab_index_o), .lanes_i(fab_lanes_o),
        .wdata_i(fab_wdata_o), .delay_i(delay), .ack_o(fab_ack_i), .rdata_o(fab_rdata_i));
    always #5 clk_i = ~clk_i;
    // ==========================================================================
    // Host bus tasks and comparison
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic host_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        host_addr_i <= a;
        host_wdata_i <= d;
        host_wr_i <= 1'b1;
        @(posedge clk_i);
        host_wr_i <= 1'b0;
    endtask
    task automatic host_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_i);
        host_addr_i <= a;
        host_rd_i <= 1'b1;
        @(posedge clk_i);
        host_rd_i <= 1'b0;
        #1;
        d = host_rdata_o;
    endtask
    // Poll the pending flag; a bounded count keeps a stuck access from hanging
    task automatic wait_idle();
        logic [31:0] s;
        for (int k = 0; k < 50; k++) begin
            host_read(`SCIFC_OFS_CMD, s);
            if (s[31] === 1'b0) return;
        end
        n_errors++;
        $display("ERROR %0t pending flag never cleared", $time);
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100us;
        n_errors++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
    // ==========================================================================
    // Main sequence
    initial begin
        int p;
        logic [15:0] r;
        reset_i = 1'b1;
        {host_addr_i, host_wr_i, host_rd_i, host_wdata_i} = '0;
        {full_dup_i, an_en_i, an_done_i, lp_able_i} = '0;
        {adv_pause_i, adv_asym_i, lp_pause_i, lp_asym_i} = '0;
        delay = 4'hF;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        host_read(`SCIFC_OFS_CMD, v);
        check(v, 32'h0000_0000);
        check(32'(fab_req_o), 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            p = i % 3;
            r = rows[i];
            host_write(fc_ofs[p], {28'h000_0000, r[15:12]});
            {full_dup_i[p], an_en_i[p], an_done_i[p], lp_able_i[p]} <= r[11:8];
            {adv_pause_i[p], adv_asym_i[p], lp_pause_i[p], lp_asym_i[p]} <= r[7:4];
            repeat (2) @(posedge clk_i);
            #1;
            check(32'(tx_fc_en_o[p]), 32'(r[1]));
            check(32'(rx_fc_en_o[p]), 32'(r[0]));
        end
        host_write(`SCIFC_OFS_FC_PORT1, 32'hFFFF_FFFF);
        host_read(`SCIFC_OFS_FC_PORT1, v);
        check(v, 32'h0000_000F);
        host_write(`SCIFC_OFS_DATA, 32'h1234_5678);
        host_write(`SCIFC_OFS_CMD, 32'h8003_0005);
        #1;
        check({10'h000, fab_req_o, fab_rd_o, fab_lanes_o, fab_index_o}, 32'h0023_0005);
        check(fab_wdata_o, 32'h1234_5678);
        host_write(`SCIFC_OFS_DATA, 32'hDEAD_BEEF);
        host_read(`SCIFC_OFS_CMD, v);
        check(v, 32'h8003_0005);
        host_read(`SCIFC_OFS_FC_STAT, v);
        check(v, 32'h0000_0132);
        wait_idle();
        check(fab.mem[5], 32'h0000_5678);
        host_read(`SCIFC_OFS_DATA, v);
        check(v, 32'h1234_5678);
        delay <= 4'h0;
        host_write(`SCIFC_OFS_CMD, 32'hC00F_0005);
        wait_idle();
        host_read(`SCIFC_OFS_DATA, v);
        check(v, 32'h0000_5678);
        host_write(`SCIFC_OFS_CMD, 32'h200F_0010);
        host_write(`SCIFC_OFS_DATA, 32'hA0A0_0010);
        wait_idle();
        host_write(`SCIFC_OFS_DATA, 32'hB0B0_0011);
        wait_idle();
        host_read(`SCIFC_OFS_CMD, v);
        check(v, 32'h200F_0012);
        check(fab.mem[17], 32'hB0B0_0011);
        host_write(`SCIFC_OFS_CMD, 32'h100F_0021);
        host_write(`SCIFC_OFS_DATA, 32'hC0C0_0021);
        wait_idle();
        host_read(`SCIFC_OFS_CMD, v);
        check(v, 32'h100F_0020);
        host_write(`SCIFC_OFS_CMD, 32'hE00F_0010);
        wait_idle();
        host_read(`SCIFC_OFS_DATA, v);
        check(v, 32'hA0A0_0010);
        check({15'h0000, fab_req_o, fab_index_o}, 32'h0001_0011);
        wait_idle();
        host_write(`SCIFC_OFS_CMD, 32'h400F_0011);
        host_read(`SCIFC_OFS_DATA, v);
        check(v, 32'hB0B0_0011);
        check(32'(fab_req_o), 32'h0000_0000);
        host_write(12'h20C, 32'hCAFE_0003);
        #1;
        check({10'h000, fab_req_o, fab_rd_o, fab_lanes_o, fab_index_o}, 32'h002F_0003);
        wait_idle();
        check(fab.mem[3], 32'hCAFE_0003);
        host_write(12'h2FC, 32'hFACE_003F);
        wait_idle();
        check(fab.mem[63], 32'hFACE_003F);
        host_read(12'h200, v);
        check(v, 32'h0000_0000);
        host_read(12'h0FC, v);
        check(v, 32'h0000_0000);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        host_read(`SCIFC_OFS_FC_PORT1, v);
        check(v, 32'h0000_0000);
        host_read(`SCIFC_OFS_CMD, v);
        check(v, 32'h0000_0000);
        stop_test();
    end
endmodule
